// ==== inc/upgrade_pkg.sv ====
/*
 Shared constants for the remote upgrade shift interface: register widths,
 reset values, timing counts and the control-register field layout.
 Assumes a 10 MHz system clock.
*/
package upgrade_pkg;
   localparam int CTRL_W = 16;
   localparam int STAT_W = 4;
   localparam int SHIFT_W = CTRL_W + STAT_W;
   localparam int CTRL_PAGE_LSB = 0;
   localparam int CTRL_PAGE_W = 7;
   localparam int CTRL_APP_BIT = 7;
   localparam int CTRL_WDOG_LSB = 8;
   localparam int CTRL_WDOG_W = 8;
   localparam int STAT_CORE_BIT = 0;
   localparam int STAT_WDOG_BIT = 1;
   localparam logic [CTRL_W-1:0] CTRL_RST = 16'h0000;
   localparam logic [CTRL_W-1:0] CTRL_LOCAL_APP = 16'h0081;
   localparam logic [CTRL_PAGE_W-1:0] FACTORY_PAGE = 7'h00;
   localparam int FIFO_DEPTH = 32;
   localparam int WDOG_UNIT_NS = 3200;
   localparam int CLK_NS = 100;
   localparam int WDOG_UNIT_CYC = (WDOG_UNIT_NS + CLK_NS - 1) / CLK_NS;
   localparam int WDOG_CNT_W = 24;
   localparam int RECONF_HOLD_CYC = 1;
endpackage

// ==== verilog/remote_upgrade_shift_interface.sv ====
/*
 Remote upgrade shift port and its reconfiguration control, with a FIFO
 that carries serial-out bits to the user side.
 Assumes user logic drives all link inputs asynchronously to clk_sys_i;
 the shift clock is sampled and only its rising edges act.
*/
`timescale 1ns/100ps
// Function
// [RQ1] A falling edge of watchdog_reload_n reloads the watchdog with its start count.
// [RQ2] Driving reconfig_request_n low starts a reconfiguration cycle.
// [RQ3] In remote mode a request from the factory image loads the application page of the control register.
// [RQ4] In remote mode a request from an application image loads the factory image.
// [RQ5] In local mode every request loads the application image.
// [RQ6] The shift and update registers act only on rising shift clock edges.
// [RQ7] With shift select high the shift register shifts left each rising edge.
// [RQ8] With both selects low the update register loads from the shift register; the code loads it only in remote mode while the factory image runs.
// [RQ9] With shift low and capture high the shift register captures status plus control or update.
// [RQ10] The capture select is ignored while shift select is high.
// [RQ11] In local mode a low capture select does nothing and the update register is never written.
// [RQ12] Serial input enters the shift register on rising edges while shift select is high.
// [RQ13] The serial output shows shift register data, new each rising edge.
// [RQ14] The port lets status, control and update contents be read and the update register written.
// [RQ15] When the reconfiguration request returns high the update register is copied into control; code does so only in remote mode from the factory image.
// [RQ16] Watchdog reload is honoured only for an application image in remote mode.
// [RQ17] User logic keeps selects stable around edges and completes shifts before update or reconfig.

// ============================================================
// FIFO
module upgrade_bit_fifo #(
   parameter int WIDTH = 1,
   parameter int DEPTH = 32
) (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   // Fill side
   input wire logic [WIDTH-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   // Drain side
   output logic [WIDTH-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   wire push = in_valid_i && (count != (AW+1)'(DEPTH));
   wire pop = out_ready_i && (count != '0);
   assign in_ready_o = (count != (AW+1)'(DEPTH));
   assign out_valid_o = (count != '0);
   assign out_data_o = mem[rd_ptr];
   always_ff @(posedge clk_sys_i) begin
      if (ce_i && push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else if (ce_i) begin
         if (push) wr_ptr <= AW'((wr_ptr + 1'b1) % DEPTH);
         if (pop) rd_ptr <= AW'((rd_ptr + 1'b1) % DEPTH);
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // upgrade_bit_fifo

// ============================================================
// Top
module remote_upgrade_shift_interface
   import upgrade_pkg::*;
#(
   parameter int WDOG_UNIT = upgrade_pkg::WDOG_UNIT_CYC
) (
   // System
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   // Mode straps
   input wire logic remote_mode_i,
   // User logic link
   input wire logic upgrade_shift_clock_i,
   input wire logic shift_or_load_select_i,
   input wire logic capture_or_update_select_i,
   input wire logic upgrade_serial_in_i,
   input wire logic watchdog_reload_n_i,
   input wire logic reconfig_request_n_i,
   output logic upgrade_serial_out_o,
   // Serial-out bit stream
   output logic dout_bit_o,
   output logic dout_valid_o,
   input wire logic dout_ready_i,
   // Configuration side
   output logic reconfig_start_o,
   output logic [upgrade_pkg::CTRL_PAGE_W-1:0] load_page_o,
   output logic app_image_o,
   output logic [upgrade_pkg::CTRL_W-1:0] control_o,
   output logic watchdog_timeout_o
);
   import upgrade_pkg::*;

   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_REQ = 2'b01,
      ST_LOAD = 2'b10
   } cfg_state_e;

   // ============================================================
   // Input synchronisers
   localparam int NSYNC = 6;
   logic [NSYNC-1:0] sync1;
   logic [NSYNC-1:0] sync2;
   logic [NSYNC-1:0] prev;
   wire [NSYNC-1:0] raw_in = {reconfig_request_n_i, watchdog_reload_n_i, upgrade_serial_in_i,
                              capture_or_update_select_i, shift_or_load_select_i, upgrade_shift_clock_i};
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync1 <= 6'h30;
         sync2 <= 6'h30;
         prev <= 6'h30;
      end else if (ce_i) begin
         sync1 <= raw_in;
         sync2 <= sync1;
         prev <= sync2;
      end
   end
   // Selects and data are sampled one system cycle before the shift clock edge, so they must be stable
   wire sclk_rise = sync2[0] && !prev[0]; // RQ6
   wire sel_shift = prev[1];
   wire sel_capt = prev[2];
   wire din = prev[3];
   wire reload_fall = !sync2[4] && prev[4]; // RQ1
   wire req_fall = !sync2[5] && prev[5]; // RQ2
   wire req_rise = sync2[5] && !prev[5]; // RQ15

   // ============================================================
   // Shift, update and control registers
   logic [SHIFT_W-1:0] shift_reg;
   logic [CTRL_W-1:0] update_reg;
   logic [CTRL_W-1:0] control;
   logic [STAT_W-1:0] status;
   logic app_image;
   logic remote_mode;
   logic strap_taken;
   wire do_shift = sclk_rise && sel_shift; // RQ7 RQ10 RQ12
   wire do_capture = sclk_rise && !sel_shift && sel_capt; // RQ9
   wire do_update = sclk_rise && !sel_shift && !sel_capt && remote_mode && !app_image; // RQ8 RQ11
   wire [CTRL_W-1:0] capt_word = app_image ? control : update_reg; // RQ9 RQ14
   wire [SHIFT_W-1:0] next_shift = do_shift ? {shift_reg[SHIFT_W-2:0], din} :
                                   do_capture ? {status, capt_word} : shift_reg;
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         shift_reg <= '0;
         update_reg <= CTRL_RST;
      end else if (ce_i) begin
         shift_reg <= next_shift; // RQ7 RQ9 RQ12
         if (do_update) update_reg <= shift_reg[CTRL_W-1:0]; // RQ8
      end
   end
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         upgrade_serial_out_o <= 1'b0;
      end else if (ce_i) begin
         upgrade_serial_out_o <= next_shift[SHIFT_W-1]; // RQ13
      end
   end

   // ============================================================
   // FIFO of serial-out bits, one per rising shift clock edge
   logic fifo_in_ready;
   logic fifo_bit;
   logic fifo_valid;
   upgrade_bit_fifo #(.WIDTH(1), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .in_data_i(next_shift[SHIFT_W-1]),
      .in_valid_i(sclk_rise),
      .in_ready_o(fifo_in_ready),
      .out_data_o(fifo_bit),
      .out_valid_o(fifo_valid),
      .out_ready_i(dout_ready_i && !dout_valid_o)
   );
   // Bits arriving while full are dropped: the shift clock cannot be stalled
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dout_bit_o <= 1'b0;
         dout_valid_o <= 1'b0;
      end else if (ce_i) begin
         if (dout_valid_o && dout_ready_i) begin
            dout_valid_o <= 1'b0;
         end else if (!dout_valid_o && fifo_valid && dout_ready_i) begin
            dout_bit_o <= fifo_bit;
            dout_valid_o <= 1'b1;
         end
      end
   end

   // ============================================================
   // Reconfiguration control
   cfg_state_e state;
   logic [WDOG_CNT_W-1:0] wdog_cnt;
   logic [$clog2(WDOG_UNIT+1)-1:0] unit_cnt;
   wire wdog_on = remote_mode && app_image && (state == ST_RUN); // RQ16
   wire wdog_expire = wdog_on && (wdog_cnt == '0) && (unit_cnt == '0);
   wire [WDOG_CNT_W-1:0] wdog_init = WDOG_CNT_W'({control[CTRL_WDOG_LSB +: CTRL_WDOG_W], 12'h000});
   wire [CTRL_W-1:0] req_ctrl = !remote_mode ? CTRL_LOCAL_APP : // RQ5
                                app_image ? CTRL_RST : update_reg; // RQ3 RQ4
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         remote_mode <= 1'b0;
         strap_taken <= 1'b0;
      end else if (ce_i && !strap_taken) begin
         remote_mode <= remote_mode_i;
         strap_taken <= 1'b1;
      end
   end
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state <= ST_RUN;
         control <= CTRL_RST;
         status <= '0;
         app_image <= 1'b0;
         reconfig_start_o <= 1'b0;
         watchdog_timeout_o <= 1'b0;
      end else if (ce_i) begin
         reconfig_start_o <= 1'b0;
         watchdog_timeout_o <= 1'b0;
         case (state)
            ST_RUN: begin
               if (wdog_expire) begin
                  control <= CTRL_RST;
                  status <= STAT_W'(1) << STAT_WDOG_BIT;
                  watchdog_timeout_o <= 1'b1;
                  state <= ST_LOAD;
               end else if (req_fall) begin
                  state <= ST_REQ; // RQ2
               end
            end
            ST_REQ: begin
               if (req_rise) begin
                  control <= req_ctrl; // RQ15 RQ3 RQ4 RQ5
                  status <= STAT_W'(1) << STAT_CORE_BIT;
                  state <= ST_LOAD;
               end
            end
            ST_LOAD: begin
               reconfig_start_o <= 1'b1; // RQ2
               app_image <= control[CTRL_APP_BIT];
               state <= ST_RUN;
            end
            default: state <= ST_RUN;
         endcase
      end
   end
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wdog_cnt <= '0;
         unit_cnt <= '0;
      end else if (ce_i) begin
         if (!wdog_on || reload_fall) begin
            wdog_cnt <= wdog_init; // RQ1 RQ16
            unit_cnt <= ($clog2(WDOG_UNIT+1))'(WDOG_UNIT - 1);
         end else if (unit_cnt != '0) begin
            unit_cnt <= unit_cnt - 1'b1;
         end else if (wdog_cnt != '0) begin
            wdog_cnt <= wdog_cnt - 1'b1;
            unit_cnt <= ($clog2(WDOG_UNIT+1))'(WDOG_UNIT - 1);
         end
      end
   end
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         load_page_o <= FACTORY_PAGE;
         app_image_o <= 1'b0;
         control_o <= CTRL_RST;
      end else if (ce_i) begin
         load_page_o <= control[CTRL_PAGE_LSB +: CTRL_PAGE_W];
         app_image_o <= app_image;
         control_o <= control;
      end
   end

   // ============================================================
   // Checks
   sequence s_shift_edge;
      sclk_rise && sel_shift;
   endsequence
   a_shift_left: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      ce_i and s_shift_edge |=> shift_reg == {$past(shift_reg[SHIFT_W-2:0]), $past(din)}) // RQ7
      else $error("shift register did not shift left");
   a_no_edge_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      ce_i && !sclk_rise |=> $stable(shift_reg)) // RQ6
      else $error("shift register changed without shift clock edge");
   a_update_load: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      ce_i && do_update |=> update_reg == $past(shift_reg[CTRL_W-1:0])) // RQ8
      else $error("update register not loaded");
   a_local_noupd: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      !remote_mode && strap_taken |=> $stable(update_reg)) // RQ11
      else $error("update register written in local mode");
   a_capture_word: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      ce_i && do_capture |=> shift_reg == {$past(status), $past(capt_word)}) // RQ9
      else $error("capture word wrong");
   a_dout_msb: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      ce_i |=> upgrade_serial_out_o == shift_reg[SHIFT_W-1]) // RQ13
      else $error("serial out does not show shift msb");
   sequence s_req_done;
      state == ST_REQ && req_rise && ce_i;
   endsequence
   a_reconf_start: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      s_req_done |=> ce_i [*1] ##1 reconfig_start_o) // RQ2
      else $error("reconfiguration not started");
   a_ctrl_copy: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      s_req_done and (remote_mode && !app_image) |=> control == $past(update_reg)) // RQ15
      else $error("control not copied from update");
   a_app_factory: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      s_req_done and (remote_mode && app_image) |=> control == CTRL_RST) // RQ4
      else $error("application request did not select factory");
   a_local_app: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      s_req_done and (!remote_mode) |=> control == CTRL_LOCAL_APP) // RQ5
      else $error("local request did not select application");
   a_wdog_reload: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      ce_i && wdog_on && reload_fall |=> wdog_cnt == $past(wdog_init)) // RQ1
      else $error("watchdog not reloaded");
   a_wdog_off: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      !(remote_mode && app_image) |=> !watchdog_timeout_o) // RQ16
      else $error("watchdog expired while disabled");
endmodule // remote_upgrade_shift_interface

// ==== testbench/user_logic_model.sv ====
/*
 Model of the user logic that drives the shift port.
 Assumes each task is entered right after a clk_sys_i edge.
*/
`timescale 1ns/100ps
// ==========
// Partner
module user_logic_model (
   input wire logic clk_sys_i,
   // Link
   output logic sclk_o,
   output logic shift_o,
   output logic capt_o,
   output logic din_o,
   output logic reload_n_o,
   output logic req_n_o
);
   initial begin
      {sclk_o, shift_o, capt_o, din_o} = 4'h0;
      {reload_n_o, req_n_o} = 2'h3;
   end
   // Selects stand 4 cycles before and 4 after the rise
   task automatic clock_once(input logic s, input logic c, input logic d);
      @(posedge clk_sys_i);
      shift_o <= s;
      capt_o <= c;
      din_o <= d;
      repeat (4) @(posedge clk_sys_i);
      sclk_o <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      sclk_o <= 1'b0;
      // Released data line must not keep its last value
      din_o <= ~d;
   endtask
   task automatic pulse_low(input logic req);
      @(posedge clk_sys_i);
      if (req) begin
         req_n_o <= 1'b0;
      end else begin
         reload_n_o <= 1'b0;
      end
      repeat (6) @(posedge clk_sys_i);
      {req_n_o, reload_n_o} <= 2'h3;
   endtask
endmodule // user_logic_model

// ==== testbench/testbench.sv ====
/*
 Self-checking bench for the remote upgrade shift interface.
 Assumes the user logic model on the link and a 10 MHz clock.
*/
`timescale 1ns/100ps
// ==========
// Bench
module testbench;
   import upgrade_pkg::*;
   logic clk_sys_i;
   logic rst_n_i;
   logic remote_mode_i;
   logic dout_ready_i = 1'b0;
   logic stall = 1'b0;
   logic ce = 1'b1;
   int rc_mark;
   wire sclk, shs, cps, sdin, rl_n, rq_n;
   logic sout, dbit, dval, rc_start, app_img, wd_to;
   logic [CTRL_PAGE_W-1:0] page;
   logic [CTRL_W-1:0] ctrl, upd, ctl, word;
   logic [STAT_W-1:0] st;
   logic [SHIFT_W-1:0] sr;
   logic app, rem;
   logic exp_q[$];
   int bad_count = 0;
   int n_tests = 0;
   int seed = 32'hda5b;
   int rc_seen = 0;
   int wd_seen = 0;

   initial begin
      clk_sys_i = 1'b0;
      forever #50 clk_sys_i = ~clk_sys_i;
   end

   user_logic_model ul (.clk_sys_i(clk_sys_i), .sclk_o(sclk), .shift_o(shs), .capt_o(cps),
      .din_o(sdin), .reload_n_o(rl_n), .req_n_o(rq_n));

   // Short watchdog unit keeps the expiry run brief
   remote_upgrade_shift_interface #(.WDOG_UNIT(2)) uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
      .ce_i(ce), .remote_mode_i(remote_mode_i), .upgrade_shift_clock_i(sclk),
      .shift_or_load_select_i(shs), .capture_or_update_select_i(cps), .upgrade_serial_in_i(sdin),
      .watchdog_reload_n_i(rl_n), .reconfig_request_n_i(rq_n), .upgrade_serial_out_o(sout),
      .dout_bit_o(dbit), .dout_valid_o(dval), .dout_ready_i(dout_ready_i),
      .reconfig_start_o(rc_start), .load_page_o(page), .app_image_o(app_img),
      .control_o(ctrl), .watchdog_timeout_o(wd_to));

   // ==========
   // Checks
   task automatic cmp_bit(input logic got, input logic exp, input string what);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: %s got %b want %b", $time, what, got, exp);
      end
   endtask
   task automatic cmp_word(input logic [CTRL_W-1:0] got, input logic [CTRL_W-1:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Stream watcher; the drain side stalls at random
   always @(posedge clk_sys_i) begin
      if (rc_start === 1'b1) rc_seen++;
      if (wd_to === 1'b1) wd_seen++;
      if (dval === 1'b1 && dout_ready_i) begin
         if (exp_q.size() == 0) begin
            bad_count++;
            $display("CHECK FAILED at %0t: unexpected stream bit", $time);
         end else begin
            cmp_bit(dbit, exp_q.pop_front(), "stream bit");
         end
      end
      dout_ready_i <= stall ? 1'b0 : 1'($random(seed));
   end

   // ==========
   // Drivers
   task automatic ru_edge(input logic s, input logic c, input logic d);
      if (s) sr = {sr[SHIFT_W-2:0], d};
      else if (c) sr = {st, app ? ctl : upd};
      else if (rem && !app) upd = sr[CTRL_W-1:0];
      exp_q.push_back(sr[SHIFT_W-1]);
      ul.clock_once(s, c, d);
      repeat (2) @(posedge clk_sys_i);
      cmp_bit(sout, sr[SHIFT_W-1], "serial out");
   endtask
   task automatic xfer(input logic [SHIFT_W-1:0] v);
      for (int i = SHIFT_W - 1; i >= 0; i--) ru_edge(1'b1, 1'($random(seed)), v[i]);
   endtask
   task automatic read_back();
      ru_edge(1'b0, 1'b1, 1'b0);
      xfer(SHIFT_W'($random(seed)));
   endtask
   task automatic reconf(input logic exp_app);
      int n0;
      n0 = rc_seen;
      ul.pulse_low(1'b1);
      for (int i = 0; i < 20 && rc_seen == n0; i++) @(posedge clk_sys_i);
      repeat (3) @(posedge clk_sys_i);
      cmp_bit(rc_seen == n0 + 1, 1'b1, "start pulse");
      cmp_bit(app_img, exp_app, "image");
      app = exp_app;
      st = STAT_W'(1 << STAT_CORE_BIT);
   endtask
   task automatic do_reset(input logic r);
      for (int i = 0; i < 3000 && exp_q.size() > 0; i++) @(posedge clk_sys_i);
      cmp_bit(exp_q.size() == 0, 1'b1, "drained");
      rst_n_i <= 1'b0;
      remote_mode_i <= r;
      repeat (5) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      repeat (6) @(posedge clk_sys_i);
      {sr, upd, ctl, st, app, rem} = {SHIFT_W'(0), 16'h0000, CTRL_RST, 4'h0, 1'b0, r};
      cmp_bit(app_img, 1'b0, "reset image");
   endtask

   // ==========
   // Scenarios
   initial begin
      rst_n_i = 1'b0;
      remote_mode_i = 1'b1;
      do_reset(1'b1);
      word = {8'h01, 1'b1, 7'($random(seed))};
      ru_edge(1'b0, 1'b1, 1'b0);
      xfer({4'h0, word});
      stall = 1'b1;
      ru_edge(1'b0, 1'b0, 1'b0);
      read_back();
      stall = 1'b0;
      reconf(1'b1);
      cmp_word(ctrl, word, "control");
      cmp_word(16'(page), 16'(word[CTRL_PAGE_W-1:0]), "page");
      ctl = word;
      ru_edge(1'b0, 1'b0, 1'b0);
      read_back();
      reconf(1'b0);
      reconf(1'b1);
      repeat (5000) @(posedge clk_sys_i);
      ul.pulse_low(1'b0);
      repeat (5000) @(posedge clk_sys_i);
      cmp_word(16'(wd_seen), 16'h0000, "early expiry");
      for (int i = 0; i < 4000 && wd_seen == 0; i++) @(posedge clk_sys_i);
      repeat (10) @(posedge clk_sys_i);
      cmp_word(16'(wd_seen), 16'h0001, "expiry");
      cmp_bit(app_img, 1'b0, "factory after expiry");
      do_reset(1'b0);
      xfer(SHIFT_W'($random(seed)));
      ru_edge(1'b0, 1'b0, 1'b0);
      read_back();
      reconf(1'b1);
      cmp_word(ctrl, CTRL_LOCAL_APP, "local control");
      reconf(1'b1);
      // Frozen block must miss a request made while enable is low
      rc_mark = rc_seen;
      ce <= 1'b0;
      ul.pulse_low(1'b1);
      repeat (5) @(posedge clk_sys_i);
      ce <= 1'b1;
      repeat (20) @(posedge clk_sys_i);
      cmp_word(16'(rc_seen - rc_mark), 16'h0000, "frozen request");
      cmp_bit(app_img, 1'b1, "frozen image");
      do_reset(1'b0);
      print_verdict();
   end

   initial begin
      #3000000;
      bad_count++;
      $display("CHECK FAILED at %0t: run hung", $time);
      print_verdict();
   end
endmodule // testbench
